/* File: bench/adc_core_model.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Converter core and input multiplexer stand-in
// -----------------------------------------------------------------------------
module adc_core_model #(
  parameter logic [11:0] BANDGAP_CODE = 12'hBD7,  // Code seen on the bandgap input.
  parameter logic [9:0]  PIN_CODE     = 10'h2A5   // Low bits of every pin input code.
) (
  input  wire logic                          clock_i,        // System clock.
  input  wire adc_ctrl_pkg::analog_ctrl_type analog_ctrl_i,  // Steering from the block.
  input  wire logic                          core_reset_i,   // Core held in reset.
  output logic [11:0]                        result_o        // Converted code.
);
  import adc_ctrl_pkg::*;

  logic [11:0] junk_reg = 12'h5A3;

  // An unpowered or reset core gives no stable code, so it flips every cycle rather than holding.
  always_ff @(posedge clock_i) begin
    junk_reg <= ~junk_reg;
  end

  // Each pin channel carries its own code so that a wrong selection shows in the result.
  assign result_o = (!analog_ctrl_i.power_on || core_reset_i) ? junk_reg :
                    analog_ctrl_i.bandgap_input_select ? BANDGAP_CODE :
                    {analog_ctrl_i.channel_select, PIN_CODE};
endmodule : adc_core_model

/* File: bench/test_adc_sequencing_control.sv */
`timescale 1ns/1ps
module test_adc_sequencing_control;
  import adc_ctrl_pkg::*;

  logic            clock_i, arst_n_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [11:0]     core_result, code;
  logic [3:0]      port_dir, pull_high, pin_dir, pin_pull, pin_dig;
  analog_ctrl_type actl;
  logic            core_reset, tick, vref_pin, busy, irq, err;
  int              errors, cmp_count, cnt, ticks;

  adc_sequencing_control adc_sequencing_control_inst (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_result_i(core_result), .port_direction_i(port_dir), .pull_high_i(pull_high),
    .analog_ctrl_o(actl), .core_reset_o(core_reset), .core_clock_tick_o(tick),
    .pin_direction_o(pin_dir), .pin_pull_high_o(pin_pull), .pin_digital_en_o(pin_dig),
    .vref_pin_analog_o(vref_pin), .conversion_busy_o(busy), .interrupt_o(irq));

  adc_core_model adc_core_model_inst (
    .clock_i(clock_i), .analog_ctrl_i(actl), .core_reset_i(core_reset), .result_o(core_result));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task end_sim;
    $display("Comparisons %0d, mismatches %0d.", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_sim();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    #1;
  endtask : apb

  // Counts clock edges until busy falls, bounded so a stall cannot hang the run.
  task wait_idle;
    cnt = 0;
    ticks = 0;
    while (busy !== 1'b0 && cnt < 3000) begin
      @(posedge clock_i);
      #1;
      cnt++;
      ticks += int'(tick);
    end
    if (cnt >= 3000) begin
      errors++;
      end_sim();
    end
  endtask : wait_idle

  // ---------------------------------------------------------------------------
  // Clock and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  initial begin
    #200000;
    errors++;
    end_sim();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    errors = 0; cmp_count = 0; arst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; port_dir = 4'h0; pull_high = 4'hF;
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    apb(1'b0, CONTROL_ZERO_OFFSET, 32'h0);
    check("ctrl0 reset", rd, 32'h0000_0060);
    check("power on at reset", 32'(actl.power_on), 32'h0);
    apb(1'b0, PIN_ENABLE_OFFSET, 32'h0);
    check("pin enable reset", rd, 32'h0000_000F);
    check("digital enables at reset", 32'(pin_dig), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    // Pin sharing overrides with a mixed enable pattern.
    apb(1'b1, PIN_ENABLE_OFFSET, 32'h0000_0005);
    check("pin direction", 32'(pin_dir), 32'h5);
    check("pin pull high", 32'(pin_pull), 32'hA);
    check("pin digital", 32'(pin_dig), 32'hA);
    apb(1'b1, CONTROL_ONE_OFFSET, 32'h0000_0010);
    check("reference pin", 32'(vref_pin), 32'h1);
    check("reference select", 32'(actl.reference_select), 32'h1);
    apb(1'b1, INTR_OFFSET, 32'h0000_0003);
    // One conversion per divider code 0 to 6, sweeping channel, bandgap and alignment.
    for (int n = 0; n < 7; n++) begin
      // The bench clock is far faster than a real part allows; only the period count matters here.
      apb(1'b1, CONTROL_ONE_OFFSET, (n == 6) ? 32'hC6 : 32'(n));
      apb(1'b1, CONTROL_ZERO_OFFSET, 32'((n % 2) * 16 + n % 4));
      check("channel connect", 32'(actl.channel_connect), (n == 6) ? 32'h0 : 32'(1 << (n % 4)));
      check("bandgap enable", 32'(actl.bandgap_enable), 32'(n == 6));
      check("power on", 32'(actl.power_on), 32'h1);
      repeat (4) @(posedge clock_i);
      apb(1'b1, CONTROL_ZERO_OFFSET, 32'((n % 2) * 16 + n % 4 + 128));
      // Busy is registered, so it follows the start bit one edge later.
      @(posedge clock_i);
      #1;
      check("busy while start high", 32'(busy), 32'h1);
      check("core reset while start high", 32'(core_reset), 32'h1);
      apb(1'b1, CONTROL_ZERO_OFFSET, 32'((n % 2) * 16 + n % 4));
      wait_idle();
      check("conversion length ok", 32'(cnt >= (16 << n) && cnt <= (16 << n) + (1 << n) + 2), 32'h1);
      check("converter ticks", 32'(ticks), 32'h10);
      code = (n == 6) ? 12'hBD7 : {2'(n % 4), 10'h2A5};
      apb(1'b0, RESULT_LOW_OFFSET, 32'h0);
      check("result low", rd, (n % 2) ? 32'(code[7:0]) : 32'({code[3:0], 4'h0}));
      apb(1'b0, RESULT_HIGH_OFFSET, 32'h0);
      check("result high", rd, (n % 2) ? 32'(code[11:8]) : 32'(code[11:4]));
      apb(1'b0, INTR_OFFSET, 32'h0);
      check("interrupt flag", rd & 32'h4, 32'h4);
      check("interrupt out", 32'(irq), 32'h1);
      apb(1'b1, INTR_OFFSET, 32'h0000_0003);
      check("interrupt cleared", 32'(irq), 32'h0);
    end
    // Masking: the flag alone, or with only the conversion enable, raises nothing.
    apb(1'b1, INTR_OFFSET, 32'h0000_0004);
    check("masked interrupt", 32'(irq), 32'h0);
    apb(1'b1, INTR_OFFSET, 32'h0000_0006);
    check("global masked", 32'(irq), 32'h0);
    // The undefined divider never completes; powering off then holds the core down.
    apb(1'b1, CONTROL_ONE_OFFSET, 32'h0000_0007);
    apb(1'b1, CONTROL_ZERO_OFFSET, 32'h80);
    apb(1'b1, CONTROL_ZERO_OFFSET, 32'h00);
    repeat (100) @(posedge clock_i);
    check("undefined divider stalls", 32'(busy), 32'h1);
    apb(1'b1, CONTROL_ZERO_OFFSET, 32'h20);
    check("power off busy", 32'(busy), 32'h1);
    check("power off core", 32'(actl.power_on), 32'h0);
    check("power off reset", 32'(core_reset), 32'h1);
    end_sim();
  end
endmodule : test_adc_sequencing_control

/* File: hdl/adc_clock_divider.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Converter clock tick generator
// -----------------------------------------------------------------------------
module adc_clock_divider (
  input  wire logic       clock_i,    // System clock.
  input  wire logic       arst_n_i,   // Asynchronous reset, active low.
  input  wire logic       clear_i,    // Restart the prescaler.
  input  wire logic [2:0] select_i,   // Divider select code.
  output logic            tick_o      // One-cycle pulse per converter period.
);
  import adc_ctrl_pkg::*;

  logic [5:0] count_reg;
  logic [5:0] limit;

  // Code n divides by two to the n; the top code has no defined rate and stalls.
  always_comb begin
    limit = 6'((7'h01 << select_i) - 7'h01);
  end

  // Free prescaler, restarted so each conversion sees whole periods.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= 6'h00;
    end else if (clear_i || count_reg >= limit) begin
      count_reg <= 6'h00;
    end else begin
      count_reg <= count_reg + 6'h01;
    end
  end

  assign tick_o = !clear_i && (select_i != DIVIDER_UNDEFINED) && (count_reg >= limit); // R5

endmodule : adc_clock_divider

/* File: hdl/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CONTROL_ZERO_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_ONE_OFFSET  = 8'h04;
  localparam logic [7:0] PIN_ENABLE_OFFSET   = 8'h08;
  localparam logic [7:0] RESULT_LOW_OFFSET   = 8'h0C;
  localparam logic [7:0] RESULT_HIGH_OFFSET  = 8'h10;
  localparam logic [7:0] INTR_OFFSET         = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int START_BIT        = 7;
  localparam int BUSY_BIT         = 6;
  localparam int POWER_OFF_BIT    = 5;
  localparam int JUSTIFY_BIT      = 4;
  localparam int CHANNEL_LSB      = 0;
  localparam int BANDGAP_SEL_BIT  = 7;
  localparam int BANDGAP_EN_BIT   = 6;
  localparam int REF_SEL_BIT      = 4;
  localparam int DIVIDER_LSB      = 0;
  localparam int GLOBAL_IE_BIT    = 0;
  localparam int CONV_IE_BIT      = 1;
  localparam int CONV_IF_BIT      = 2;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic       POWER_OFF_RESET  = 1'b1;
  localparam logic       BUSY_RESET       = 1'b1;
  localparam logic [3:0] PIN_ENABLE_RESET = 4'hF;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CONV_PERIODS     = 16;
  localparam logic [4:0]  CONV_PERIODS_W   = 5'h10;
  localparam logic [2:0]  DIVIDER_UNDEFINED = 3'h7;
  localparam int          RESULT_BITS      = 12;

  // Control bits steering the analog side travel together.
  typedef struct packed {
    logic       power_on;
    logic       reference_select;
    logic       bandgap_enable;
    logic       bandgap_input_select;
    logic [1:0] channel_select;
    logic [3:0] channel_connect;
  } analog_ctrl_type;

endpackage : adc_ctrl_pkg

/* File: hdl/adc_sequencing_control.sv */
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// [R1] Start bit low-high-low begins conversion.
// [R2] Start held high resets converter, busy set.
// [R3] Busy clears itself when conversion ends.
// [R4] End sets flag; interrupt when enabled.
// [R5] Converter clock is system clock divided.
// [R6] Software keeps converter period above half microsecond.
// [R7] Analog powered only while power-off is zero.
// [R8] Software waits settling after power-on.
// [R9] Software powers off unused converter.
// [R10] Reference select routes external reference pin.
// [R11] Pin enable makes pin analog input.
// [R12] Analog pins lose their pull-high resistor.
// [R13] Pin enable overrides port direction.
// [R14] Conversion lasts sixteen converter clock periods.
// [R15] Bandgap select and channel pick input.
// [R16] Software sets both enables for interrupts.
// [R17] Software starts with start bit low.
// [R18] Results valid once busy falls.
// [R19] Result is twelve-bit code, full scale.
// [R20] Justify bit sets result alignment.
// [R21] Channel codes connect inputs zero to three.
// [R22] Bandgap select connects bandgap, drops channels.
// [R23] Both result bytes update with busy fall.
module adc_sequencing_control (
  input  wire logic                          clock_i,             // System clock, 200 MHz.
  input  wire logic                          arst_n_i,            // Asynchronous reset, active low.
  input  wire logic                          psel,                // APB select.
  input  wire logic                          penable,             // APB access phase.
  input  wire logic                          pwrite,              // APB direction.
  input  wire logic [7:0]                    paddr,               // APB byte address.
  input  wire logic [31:0]                   pwdata,              // APB write data.
  output logic      [31:0]                   prdata,              // APB read data.
  output logic                               pready,              // APB ready.
  output logic                               pslverr,             // APB error.
  input  wire logic [11:0]                   core_result_i,       // Converter core code.
  input  wire logic [3:0]                    port_direction_i,    // Port direction register, 1 = input.
  input  wire logic [3:0]                    pull_high_i,         // Programmed pull-high enables.
  output adc_ctrl_pkg::analog_ctrl_type      analog_ctrl_o,       // Analog core steering.
  output logic                               core_reset_o,        // Holds the converter in reset.
  output logic                               core_clock_tick_o,   // Converter clock period pulse.
  output logic      [3:0]                    pin_direction_o,     // Effective pin direction, 1 = input.
  output logic      [3:0]                    pin_pull_high_o,     // Effective pull-high enables.
  output logic      [3:0]                    pin_digital_en_o,    // Digital function enables.
  output logic                               vref_pin_analog_o,   // Reference pin taken by converter.
  output logic                               conversion_busy_o,   // Conversion in progress.
  output logic                               interrupt_o          // Converter interrupt request.
);
  import adc_ctrl_pkg::*;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic        start_reg;
  logic        power_off_reg;
  logic        justify_reg;
  logic [1:0]  channel_select_reg;
  logic        bandgap_input_select_reg;
  logic        bandgap_enable_reg;
  logic        reference_select_reg;
  logic [2:0]  clock_divider_select_reg;
  logic [3:0]  analog_pin_enable_reg;
  logic        global_ie_reg;
  logic        conv_ie_reg;
  logic        conv_if_reg;
  logic        busy_reg;
  logic        running_reg;
  logic [4:0]  period_count_reg;
  logic [11:0] result_reg;
  logic        tick;
  logic        wr_en;
  logic        rd_en;
  logic        start_rise;
  logic        start_fall;
  logic        conv_done;

  // Decodes an address against the six mapped words.
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = addr_hit(a, CONTROL_ZERO_OFFSET) || addr_hit(a, CONTROL_ONE_OFFSET) ||
             addr_hit(a, PIN_ENABLE_OFFSET) || addr_hit(a, RESULT_LOW_OFFSET) ||
             addr_hit(a, RESULT_HIGH_OFFSET) || addr_hit(a, INTR_OFFSET);
  endfunction : mapped

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  // Zero wait states; unmapped addresses answer with an error and no effect.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign wr_en   = psel && penable && pwrite && mapped(paddr);
  assign rd_en   = psel && !penable && !pwrite;

  // Control register zero fields.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_reg          <= 1'b0;
      power_off_reg      <= POWER_OFF_RESET;
      justify_reg        <= 1'b0;
      channel_select_reg <= 2'h0;
    end else if (wr_en && addr_hit(paddr, CONTROL_ZERO_OFFSET)) begin
      start_reg          <= pwdata[START_BIT];
      power_off_reg      <= pwdata[POWER_OFF_BIT];
      justify_reg        <= pwdata[JUSTIFY_BIT];
      channel_select_reg <= pwdata[CHANNEL_LSB+:2];
    end
  end

  // Control register one fields.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bandgap_input_select_reg <= 1'b0;
      bandgap_enable_reg       <= 1'b0;
      reference_select_reg     <= 1'b0;
      clock_divider_select_reg <= 3'h0;
    end else if (wr_en && addr_hit(paddr, CONTROL_ONE_OFFSET)) begin
      bandgap_input_select_reg <= pwdata[BANDGAP_SEL_BIT];
      bandgap_enable_reg       <= pwdata[BANDGAP_EN_BIT];
      reference_select_reg     <= pwdata[REF_SEL_BIT];
      clock_divider_select_reg <= pwdata[DIVIDER_LSB+:3];
    end
  end

  // Analog pin enables come out of reset all set, so no pin drives by surprise.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      analog_pin_enable_reg <= PIN_ENABLE_RESET;
    end else if (wr_en && addr_hit(paddr, PIN_ENABLE_OFFSET)) begin
      analog_pin_enable_reg <= pwdata[3:0];
    end
  end

  // Read data is registered in the setup cycle so it comes from flip-flops.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        CONTROL_ZERO_OFFSET: prdata <= {24'h000000, start_reg, busy_reg, power_off_reg, justify_reg,
                                        2'b00, channel_select_reg};
        CONTROL_ONE_OFFSET:  prdata <= {24'h000000, bandgap_input_select_reg, bandgap_enable_reg, 1'b0,
                                        reference_select_reg, 1'b0, clock_divider_select_reg};
        PIN_ENABLE_OFFSET:   prdata <= {28'h0000000, analog_pin_enable_reg};
        // Unused result bits read zero in either alignment.
        RESULT_LOW_OFFSET:   prdata <= justify_reg ? {24'h000000, result_reg[7:0]}         // R20
                                                   : {24'h000000, result_reg[3:0], 4'h0};  // R20
        RESULT_HIGH_OFFSET:  prdata <= justify_reg ? {28'h0000000, result_reg[11:8]}       // R20
                                                   : {24'h000000, result_reg[11:4]};       // R20
        INTR_OFFSET:         prdata <= {29'h00000000, conv_if_reg, conv_ie_reg, global_ie_reg};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Start sequencing
  // ---------------------------------------------------------------------------
  // The start bit is a register on this clock, so its edges are seen directly.
  logic start_prev_reg;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_reg;
    end
  end

  assign start_rise = start_reg && !start_prev_reg;
  assign start_fall = !start_reg && start_prev_reg;

  adc_clock_divider adc_clock_divider_inst (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .clear_i  (start_reg),
    .select_i (clock_divider_select_reg),
    .tick_o   (tick)
  );

  // A power-off that lands in the final period aborts the conversion, so it must not complete it.
  // Without this gate the flag and result would update for a conversion that was thrown away.
  assign conv_done = running_reg && tick && !power_off_reg && (period_count_reg == CONV_PERIODS_W - 5'h01);

  // Conversion runs while start is low and power is on; sixteen periods.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      running_reg      <= 1'b0;
      period_count_reg <= 5'h00;
    end else if (start_reg || power_off_reg) begin
      running_reg      <= 1'b0;                        // R2
      period_count_reg <= 5'h00;
    end else if (start_fall) begin
      running_reg      <= 1'b1;                        // R1
      period_count_reg <= 5'h00;
    end else if (conv_done) begin
      running_reg      <= 1'b0;                        // R14
      period_count_reg <= 5'h00;
    end else if (running_reg && tick) begin
      period_count_reg <= period_count_reg + 5'h01;    // R14
    end
  end

  // Busy is forced high by a start rise and held while start stays high.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_reg <= BUSY_RESET;
    end else if (start_reg) begin
      busy_reg <= 1'b1;                                // R2
    end else if (conv_done) begin
      busy_reg <= 1'b0;                                // R3
    end
  end

  // Result captured in the same cycle busy falls, so both bytes stay coherent.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_reg <= 12'h000;
    end else if (conv_done) begin
      result_reg <= core_result_i;                     // R18 R19 R23
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------------------
  // A completion in the clearing write's cycle wins, so no end is lost.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      global_ie_reg <= 1'b0;
      conv_ie_reg   <= 1'b0;
      conv_if_reg   <= 1'b0;
    end else begin
      if (wr_en && addr_hit(paddr, INTR_OFFSET)) begin
        global_ie_reg <= pwdata[GLOBAL_IE_BIT];
        conv_ie_reg   <= pwdata[CONV_IE_BIT];
      end
      if (conv_done) begin
        conv_if_reg <= 1'b1;                           // R4
      end else if (wr_en && addr_hit(paddr, INTR_OFFSET)) begin
        conv_if_reg <= pwdata[CONV_IF_BIT];
      end
    end
  end

  assign interrupt_o = conv_if_reg && conv_ie_reg && global_ie_reg; // R4

  // ---------------------------------------------------------------------------
  // Analog steering and pin sharing
  // ---------------------------------------------------------------------------
  always_comb begin
    analog_ctrl_o.power_on             = !power_off_reg;                  // R7
    analog_ctrl_o.reference_select     = reference_select_reg;            // R10
    analog_ctrl_o.bandgap_enable       = bandgap_enable_reg;
    analog_ctrl_o.bandgap_input_select = bandgap_input_select_reg;        // R15 R22
    analog_ctrl_o.channel_select       = channel_select_reg;              // R15
    // One-hot switch per external input; all open while the bandgap is chosen.
    analog_ctrl_o.channel_connect      = bandgap_input_select_reg ? 4'h0  // R22
                                         : 4'(4'h1 << channel_select_reg); // R21
  end

  assign core_reset_o      = start_reg || power_off_reg;                  // R2 R7
  assign core_clock_tick_o = tick && running_reg;                         // R5
  assign vref_pin_analog_o = reference_select_reg;                        // R10
  assign pin_digital_en_o  = ~analog_pin_enable_reg;                      // R11
  assign pin_pull_high_o   = pull_high_i & ~analog_pin_enable_reg;        // R12
  assign pin_direction_o   = port_direction_i | analog_pin_enable_reg;    // R13
  assign conversion_busy_o = busy_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_busy_on_start;
    @(posedge clock_i) disable iff (!arst_n_i) start_reg |=> busy_reg;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("Busy not set under start."); // R2

  property p_start_launch;
    @(posedge clock_i) disable iff (!arst_n_i) (start_fall && !power_off_reg) |=> running_reg;
  endproperty
  a_start_launch: assert property (p_start_launch) else $error("Start fall did not launch."); // R1

  property p_busy_clears;
    @(posedge clock_i) disable iff (!arst_n_i) (conv_done && !start_reg) |=> !busy_reg;
  endproperty
  a_busy_clears: assert property (p_busy_clears) else $error("Busy stayed high at end."); // R3

  property p_flag_set;
    @(posedge clock_i) disable iff (!arst_n_i) $fell(busy_reg) |-> conv_if_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Interrupt flag missing at end."); // R4

  property p_div_one_len;
    @(posedge clock_i) disable iff (!arst_n_i)
      (start_fall && !power_off_reg && clock_divider_select_reg == 3'h0 && $stable(clock_divider_select_reg))
      |-> ##17 $fell(busy_reg);
  endproperty
  a_div_one_len: assert property (p_div_one_len) else $error("Undivided conversion not 16 cycles."); // R14

  property p_result_coherent;
    @(posedge clock_i) disable iff (!arst_n_i) !$fell(busy_reg) && !busy_reg |-> $stable(result_reg);
  endproperty
  a_result_coherent: assert property (p_result_coherent) else $error("Result changed while idle."); // R23

  property p_power_gate;
    @(posedge clock_i) disable iff (!arst_n_i) power_off_reg |-> (!analog_ctrl_o.power_on && core_reset_o);
  endproperty
  a_power_gate: assert property (p_power_gate) else $error("Analog powered while off."); // R7

  property p_pin_override;
    @(posedge clock_i) disable iff (!arst_n_i)
      ((pin_direction_o & analog_pin_enable_reg) == analog_pin_enable_reg) &&
      ((pin_pull_high_o & analog_pin_enable_reg) == 4'h0);
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("Analog pin not overridden."); // R12

  property p_bandgap_isolate;
    @(posedge clock_i) disable iff (!arst_n_i) bandgap_input_select_reg |-> analog_ctrl_o.channel_connect == 4'h0;
  endproperty
  a_bandgap_isolate: assert property (p_bandgap_isolate) else $error("Channel left connected."); // R22

  // The spacing check expects the divider to stay put while a conversion runs.
  property p_tick_spacing;
    @(posedge clock_i) disable iff (!arst_n_i)
      (core_clock_tick_o && clock_divider_select_reg != 3'h0) |=> !core_clock_tick_o;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("Converter ticks too close together."); // R5

  property p_done_flag;
    @(posedge clock_i) disable iff (!arst_n_i) conv_done |=> conv_if_reg;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("Completion did not set the flag."); // R4

  property p_result_capture;
    @(posedge clock_i) disable iff (!arst_n_i) conv_done |=> result_reg == $past(core_result_i);
  endproperty
  a_result_capture: assert property (p_result_capture) else $error("Result not captured at completion."); // R18

  property p_power_abort;
    @(posedge clock_i) disable iff (!arst_n_i) power_off_reg |=> !running_reg;
  endproperty
  a_power_abort: assert property (p_power_abort) else $error("Conversion ran while powered off."); // R7

endmodule : adc_sequencing_control
